// ===== fbw_defines.svh
// offsets, field positions, reset values and timing counts of the watchdog
`ifndef FBW_DEFINES_SVH
`define FBW_DEFINES_SVH
`define FBW_CLK_PERIOD_NS  10
`define FBW_BASE_TIME_NS   1000000
`define FBW_MS_CYCLES      (`FBW_BASE_TIME_NS / `FBW_CLK_PERIOD_NS)
`define FBW_SLOW_DIV       4'hA
`define FBW_DIV_W          20
`define FBW_CNT_W          16
`define FBW_HUNT_MS        16
`define FBW_NUM_RATES      8
`define FBW_OFS_CTRL       8'h00
`define FBW_OFS_RATE_COUNT 8'h04
`define FBW_OFS_STATUS     8'h08
`define FBW_OFS_FACTORS    8'h0C
`define FBW_OFS_IRQ_STAT   8'h10
`define FBW_OFS_IRQ_EN     8'h14
`define FBW_OFS_IRQ_CLR    8'h18
`define FBW_CTRL_PROTO_BIT 0
`define FBW_ST_RATE_LSB    4
`define FBW_ST_MON_BIT     8
`define FBW_ST_TB10_BIT    9
`define FBW_FB_LSB         8
`define FBW_IRQ_MASTER_BIT 0
`define FBW_IRQ_RATE_BIT   1
`define FBW_RST_RATE_COUNT 16'h0064
`define FBW_RST_FACTOR     8'h01
`endif

// ===== fbw_pkg.sv
// types shared by the watchdog modules
package fbw_pkg;
    typedef enum logic [1:0] {
        FBW_HUNT,
        FBW_RATE_GUARD,
        FBW_MASTER_GUARD
    } fbw_state_type;

    typedef struct packed {
        logic [19:0] div;
        logic [3:0]  dec;
        logic        t1;
        logic        t10;
    } fbw_tick_type;

    typedef struct packed {
        logic [15:0] cnt;
        logic        expire;
    } fbw_tmr_type;

    typedef struct packed {
        fbw_state_type state;
        logic [2:0]    rate_idx;
        logic          proto_on;
        logic [15:0]   rate_count;
        logic          resp_mon;
        logic          tb10;
        logic [7:0]    fact_a;
        logic [7:0]    fact_b;
        logic [1:0]    irq_stat;
        logic [1:0]    irq_en;
        logic [31:0]   rdata;
        logic          proto_reset;
    } fbw_main_type;
endpackage : fbw_pkg

// ===== fbw_wd_if.sv
// time base and guard timer signals between the watchdog modules
`timescale 1ns/1ps
interface fbw_wd_if;
    logic        tick_1ms;
    logic        tick_10ms;
    logic        tick;
    logic        load;
    logic [15:0] load_val;
    logic        expire;
    modport src (output tick_1ms, output tick_10ms);
    modport tmr (input tick, input load, input load_val, output expire);
    modport ctl (input tick_1ms, input tick_10ms, input expire,
                 output tick, output load, output load_val);
endinterface : fbw_wd_if

// ===== fbw_tick_gen.sv
// 1 ms and 10 ms tick pulses from the system clock
`timescale 1ns/1ps
`include "fbw_defines.svh"
module fbw_tick_gen #(
    parameter int MS_CYCLES = `FBW_MS_CYCLES
) (
    input  wire logic sys_clk_in,
    input  wire logic rstn_in,
    fbw_wd_if.src     wd
);
    import fbw_pkg::*;
    localparam logic [19:0] DIV_LAST = 20'(MS_CYCLES - 1);
    fbw_tick_type q, d;

    always_comb begin
        d = q;
        d.t1 = 1'b0;
        d.t10 = 1'b0;
        if (q.div == DIV_LAST) begin
            d.div = '0;
            d.t1 = 1'b1;
            if (q.dec == `FBW_SLOW_DIV - 4'h1) begin
                d.dec = '0;
                d.t10 = 1'b1;
            end else begin
                d.dec = q.dec + 4'h1;
            end
        end else begin
            d.div = q.div + 20'h1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign wd.tick_1ms = q.t1;
    assign wd.tick_10ms = q.t10;
endmodule : fbw_tick_gen

// ===== fbw_guard_timer.sv
// down counter in ticks, one-cycle expire pulse
`timescale 1ns/1ps
module fbw_guard_timer (
    input  wire logic sys_clk_in,
    input  wire logic rstn_in,
    fbw_wd_if.tmr     wd
);
    import fbw_pkg::*;
    fbw_tmr_type q, d;

    always_comb begin
        d = q;
        d.expire = 1'b0;
        // a load of zero parks the timer, it never expires
        if (wd.load) begin
            d.cnt = wd.load_val;
        end else if (wd.tick && q.cnt != 16'h0000) begin
            d.cnt = q.cnt - 16'h0001;
            d.expire = (q.cnt == 16'h0001);
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign wd.expire = q.expire;

    property p_expire_pulse;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        q.expire |-> q.cnt == 16'h0000;
    endproperty
    a_expire_pulse: assert property (p_expire_pulse)
        else $error("timer expired with count left");
endmodule : fbw_guard_timer

// ===== fbw_watchdog.sv
// baud rate hunt, rate guard and master guard watchdog
//
// Summary of operation
// - hunt after reset and rate guard expiry
// - every hunt starts at highest rate
// - hunt timeout steps to next lower rate, from the lowest it wraps to the highest
// - good frame in hunt enters rate guard
// - rate guard time is count times 10 ms
// - own-address frame restarts rate guard
// - protocol on: set-param with monitoring enters master guard
// - monitoring off keeps rate guard
// - rate guard timeout leaves protocol untouched
// - master guard time is base times factors
// - factors and base taken from parameter byte
// - master guard expiry: rate guard plus interrupt
// - master guard expiry resets protocol machine
// - new master: follow monitoring flag
`timescale 1ns/1ps
`include "fbw_defines.svh"
module fbw_watchdog #(
    parameter int MS_CYCLES = `FBW_MS_CYCLES,
    parameter int NUM_RATES = `FBW_NUM_RATES,
    parameter int HUNT_MS   = `FBW_HUNT_MS
) (
    input  wire logic                 sys_clk_in,
    input  wire logic                 rstn_in,
    input  wire logic [7:0]           reg_addr_in,
    input  wire logic [31:0]          reg_wdata_in,
    input  wire logic                 reg_wr_in,
    input  wire logic                 reg_rd_in,
    output logic [31:0]               reg_rdata_out,
    input  wire logic                 frame_good_in,
    input  wire logic                 frame_own_addr_in,
    input  wire logic                 frame_from_master_in,
    input  wire logic                 set_param_in,
    input  wire logic                 param_mon_on_in,
    input  wire logic                 param_tb10_in,
    input  wire logic [7:0]           param_factor_a_in,
    input  wire logic [7:0]           param_factor_b_in,
    input  wire logic                 master_change_in,
    output logic [2:0]                rate_sel_out,
    output fbw_pkg::fbw_state_type    guard_state_out,
    output logic                      proto_reset_out,
    output logic                      irq_out
);
    import fbw_pkg::*;

    localparam logic [2:0]  RATE_LAST = 3'(NUM_RATES - 1);
    localparam logic [15:0] HUNT_VAL  = 16'(HUNT_MS);

    fbw_main_type q, d;
    fbw_wd_if     wd ();
    logic         load;
    logic [15:0]  load_val;
    logic         tick;
    logic [1:0]   ev;
    logic         wr_hit;
    logic         armed_q;

    // product of the two guard factors in base ticks
    function automatic logic [15:0] fbw_product(input logic [7:0] a,
                                                input logic [7:0] b);
        fbw_product = 16'(a) * 16'(b);
    endfunction : fbw_product

    fbw_tick_gen #(
        .MS_CYCLES (MS_CYCLES)
    ) u_tick (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .wd         (wd)
    );

    fbw_guard_timer u_timer (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .wd         (wd)
    );

    always_comb begin
        d = q;
        d.proto_reset = 1'b0;
        d.rdata = 32'h0000_0000;
        load = 1'b0;
        load_val = 16'h0000;
        ev = 2'b00;
        wr_hit = reg_wr_in;

        // register writes
        if (wr_hit) begin
            case (reg_addr_in)
                `FBW_OFS_CTRL: begin
                    d.proto_on = reg_wdata_in[`FBW_CTRL_PROTO_BIT];
                end
                `FBW_OFS_RATE_COUNT: begin
                    d.rate_count = reg_wdata_in[15:0];
                end
                `FBW_OFS_IRQ_EN: begin
                    d.irq_en = reg_wdata_in[1:0];
                end
                default: begin
                end
            endcase
        end

        // parameter byte fields latched on every set-param frame
        if (set_param_in) begin
            d.resp_mon = param_mon_on_in;
            d.tb10 = param_tb10_in;
            d.fact_a = param_factor_a_in;
            d.fact_b = param_factor_b_in;
        end

        case (q.state)
            FBW_HUNT: begin
                if (frame_good_in) begin
                    d.state = FBW_RATE_GUARD;
                    load = 1'b1;
                    load_val = q.rate_count;
                end else if (!armed_q) begin
                    // reset parks the timer, so arm the first trial
                    load = 1'b1;
                    load_val = HUNT_VAL;
                end else if (wd.expire) begin
                    // wrap to the top so the hunt never stalls
                    d.rate_idx = (q.rate_idx == RATE_LAST) ?
                                 3'h0 : q.rate_idx + 3'h1;
                    load = 1'b1;
                    load_val = HUNT_VAL;
                end
            end
            FBW_RATE_GUARD: begin
                if (q.proto_on && set_param_in && param_mon_on_in) begin
                    d.state = FBW_MASTER_GUARD;
                    load = 1'b1;
                    load_val = fbw_product(param_factor_a_in,
                                           param_factor_b_in);
                end else if (master_change_in && q.proto_on
                             && d.resp_mon) begin
                    d.state = FBW_MASTER_GUARD;
                    load = 1'b1;
                    load_val = fbw_product(q.fact_a, q.fact_b);
                end else if (frame_good_in && frame_own_addr_in) begin
                    load = 1'b1;
                    load_val = q.rate_count;
                end else if (wd.expire) begin
                    // protocol machine keeps data exchange
                    d.state = FBW_HUNT;
                    d.rate_idx = 3'h0;
                    ev[`FBW_IRQ_RATE_BIT] = 1'b1;
                    load = 1'b1;
                    load_val = HUNT_VAL;
                end
            end
            FBW_MASTER_GUARD: begin
                if (set_param_in && !param_mon_on_in) begin
                    d.state = FBW_RATE_GUARD;
                    load = 1'b1;
                    load_val = q.rate_count;
                end else if (master_change_in && !q.resp_mon) begin
                    d.state = FBW_RATE_GUARD;
                    load = 1'b1;
                    load_val = q.rate_count;
                end else if (set_param_in) begin
                    load = 1'b1;
                    load_val = fbw_product(param_factor_a_in,
                                           param_factor_b_in);
                end else if (master_change_in ||
                             (frame_good_in && frame_from_master_in)) begin
                    load = 1'b1;
                    // factors of one each are not trapped here
                    load_val = fbw_product(q.fact_a, q.fact_b);
                end else if (wd.expire) begin
                    d.state = FBW_RATE_GUARD;
                    ev[`FBW_IRQ_MASTER_BIT] = 1'b1;
                    d.proto_reset = 1'b1;
                    load = 1'b1;
                    load_val = q.rate_count;
                end
            end
            default: begin
                d.state = FBW_HUNT;
                d.rate_idx = 3'h0;
            end
        endcase

        // set wins over a clear in the same cycle
        if (wr_hit && reg_addr_in == `FBW_OFS_IRQ_CLR) begin
            d.irq_stat = (q.irq_stat & ~reg_wdata_in[1:0]) | ev;
        end else begin
            d.irq_stat = q.irq_stat | ev;
        end

        if (reg_rd_in) begin
            case (reg_addr_in)
                `FBW_OFS_CTRL: begin
                    d.rdata[`FBW_CTRL_PROTO_BIT] = q.proto_on;
                end
                `FBW_OFS_RATE_COUNT: begin
                    d.rdata[15:0] = q.rate_count;
                end
                `FBW_OFS_STATUS: begin
                    d.rdata[1:0] = q.state;
                    d.rdata[`FBW_ST_RATE_LSB +: 3] = q.rate_idx;
                    d.rdata[`FBW_ST_MON_BIT] = q.resp_mon;
                    d.rdata[`FBW_ST_TB10_BIT] = q.tb10;
                end
                `FBW_OFS_FACTORS: begin
                    d.rdata[7:0] = q.fact_a;
                    d.rdata[`FBW_FB_LSB +: 8] = q.fact_b;
                end
                `FBW_OFS_IRQ_STAT: begin
                    d.rdata[1:0] = q.irq_stat;
                end
                `FBW_OFS_IRQ_EN: begin
                    d.rdata[1:0] = q.irq_en;
                end
                default: begin
                end
            endcase
        end
    end

    // tick source follows the state of the current cycle
    always_comb begin
        case (q.state)
            FBW_HUNT:         tick = wd.tick_1ms;
            FBW_RATE_GUARD:   tick = wd.tick_10ms;
            FBW_MASTER_GUARD: tick = q.tb10 ? wd.tick_10ms
                                            : wd.tick_1ms;
            default:          tick = 1'b0;
        endcase
    end

    assign wd.tick = tick;
    assign wd.load = load;
    assign wd.load_val = load_val;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            q.state <= FBW_HUNT;
            q.rate_idx <= 3'h0;
            q.proto_on <= 1'b0;
            q.rate_count <= `FBW_RST_RATE_COUNT;
            q.resp_mon <= 1'b0;
            q.tb10 <= 1'b0;
            q.fact_a <= `FBW_RST_FACTOR;
            q.fact_b <= `FBW_RST_FACTOR;
            q.irq_stat <= 2'b00;
            q.irq_en <= 2'b00;
            q.rdata <= 32'h0000_0000;
            q.proto_reset <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // hunt timer armed right after reset release
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            armed_q <= 1'b0;
        end else begin
            armed_q <= 1'b1;
        end
    end

    assign reg_rdata_out = q.rdata;
    assign rate_sel_out = q.rate_idx;
    assign guard_state_out = q.state;
    assign proto_reset_out = q.proto_reset;
    assign irq_out = |(q.irq_stat & q.irq_en);

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_rate_expire;
        q.state == FBW_RATE_GUARD && wd.expire && !frame_good_in
        && !set_param_in && !master_change_in;
    endsequence

    sequence s_master_expire;
        q.state == FBW_MASTER_GUARD && wd.expire && !frame_good_in
        && !set_param_in && !master_change_in;
    endsequence

    property p_rate_lost;
        s_rate_expire |=> q.state == FBW_HUNT && q.rate_idx == 3'h0;
    endproperty
    a_rate_lost: assert property (p_rate_lost)
        else $error("rate guard expiry did not restart hunt at top");

    property p_hunt_step;
        q.state == FBW_HUNT && wd.expire && !frame_good_in
        && q.rate_idx != RATE_LAST
        |=> q.rate_idx == $past(q.rate_idx) + 3'h1;
    endproperty
    a_hunt_step: assert property (p_hunt_step)
        else $error("hunt did not step to next lower rate");

    property p_hunt_lock;
        q.state == FBW_HUNT && frame_good_in
        |-> load && load_val == q.rate_count ##1 q.state == FBW_RATE_GUARD;
    endproperty
    a_hunt_lock: assert property (p_hunt_lock)
        else $error("good frame in hunt did not lock rate");

    property p_own_restart;
        q.state == FBW_RATE_GUARD && frame_good_in && frame_own_addr_in
        && !master_change_in && !set_param_in
        |-> load && load_val == q.rate_count && tick == wd.tick_10ms;
    endproperty
    a_own_restart: assert property (p_own_restart)
        else $error("own-address frame did not restart rate guard");

    property p_enter_master;
        q.state == FBW_RATE_GUARD && q.proto_on && set_param_in
        && param_mon_on_in
        |=> q.state == FBW_MASTER_GUARD && $past(load)
            && $past(load_val) == 16'($past(param_factor_a_in))
                                  * 16'($past(param_factor_b_in));
    endproperty
    a_enter_master: assert property (p_enter_master)
        else $error("set-param with monitoring did not enter master guard");

    property p_mon_off;
        q.state == FBW_RATE_GUARD && set_param_in && !param_mon_on_in
        |=> q.state != FBW_MASTER_GUARD;
    endproperty
    a_mon_off: assert property (p_mon_off)
        else $error("monitoring off entered master guard");

    property p_no_proto_reset;
        s_rate_expire |=> !proto_reset_out [*2];
    endproperty
    a_no_proto_reset: assert property (p_no_proto_reset)
        else $error("rate guard expiry reset protocol machine");

    property p_master_expire;
        s_master_expire |=> q.state == FBW_RATE_GUARD && proto_reset_out
        && q.irq_stat[`FBW_IRQ_MASTER_BIT] ##1 !proto_reset_out;
    endproperty
    a_master_expire: assert property (p_master_expire)
        else $error("master guard expiry handled wrongly");

    property p_new_master;
        q.state == FBW_MASTER_GUARD && master_change_in && !set_param_in
        |=> q.state == ($past(q.resp_mon) ? FBW_MASTER_GUARD
                                          : FBW_RATE_GUARD);
    endproperty
    a_new_master: assert property (p_new_master)
        else $error("master takeover did not follow monitoring flag");

    property p_master_frame;
        q.state == FBW_MASTER_GUARD && frame_good_in && frame_from_master_in
        && !set_param_in && !master_change_in
        |-> load && load_val == fbw_product(q.fact_a, q.fact_b);
    endproperty
    a_master_frame: assert property (p_master_frame)
        else $error("master frame did not restart master guard");

    property p_start_hunt;
        !armed_q |-> q.state == FBW_HUNT && q.rate_idx == 3'h0;
    endproperty
    a_start_hunt: assert property (p_start_hunt)
        else $error("not hunting at top rate after reset");
endmodule : fbw_watchdog

// ===== fbw_master_model.sv
// fieldbus master station stub: frame, parameter and take-over pulses
`timescale 1ns/1ps
module fbw_master_model (
    input  wire logic       sys_clk_in,
    output logic            good_out,
    output logic            own_out,
    output logic            from_m_out,
    output logic            param_out,
    output logic            mon_out,
    output logic            tb10_out,
    output logic [7:0]      fa_out,
    output logic [7:0]      fb_out,
    output logic            take_out
);
    initial begin
        {good_out, own_out, from_m_out, param_out, take_out} = 5'h00;
        {mon_out, tb10_out} = 2'h0;
        fa_out = 8'h01;
        fb_out = 8'h02;
    end

    // one complete error-free frame, qualifiers valid with the pulse
    task frame(input logic own, input logic fm);
        @(posedge sys_clk_in);
        good_out   <= 1'b1;
        own_out    <= own;
        from_m_out <= fm;
        @(posedge sys_clk_in);
        good_out   <= 1'b0;
        own_out    <= 1'b0;
        from_m_out <= 1'b0;
    endtask : frame

    task param(input logic mon, input logic tb, input logic [7:0] a,
               input logic [7:0] b);
        logic [7:0] bb;
        bb = (a == 8'h01 && b == 8'h01) ? 8'h02 : b;
        @(posedge sys_clk_in);
        param_out <= 1'b1;
        mon_out   <= mon;
        tb10_out  <= tb;
        fa_out    <= a;
        fb_out    <= bb;
        @(posedge sys_clk_in);
        // fields invalid after the pulse, so show something else
        param_out <= 1'b0;
        mon_out   <= ~mon;
        tb10_out  <= ~tb;
        fa_out    <= ~a;
        fb_out    <= ~bb;
    endtask : param

    task take_over();
        @(posedge sys_clk_in);
        take_out <= 1'b1;
        @(posedge sys_clk_in);
        take_out <= 1'b0;
    endtask : take_over
endmodule : fbw_master_model

// ===== fieldbus_rate_and_master_watchdog_bench.sv
// self-checking bench for the rate and master watchdog
`timescale 1ns/1ps
`include "fbw_defines.svh"
`define CHK(act, exp) begin n_tests++; if ((act) !== (exp)) begin \
    failures++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, \
    (act), (exp)); end end
module fieldbus_rate_and_master_watchdog_bench;
    import fbw_pkg::*;
    logic          clk = 1'b0;
    logic          rstn = 1'b0;
    logic [7:0]    addr = 8'h00;
    logic [31:0]   wdata = 32'h00000000;
    logic          wr = 1'b0;
    logic          rd = 1'b0;
    logic [31:0]   rdata;
    logic          good, own, fm, sp, mon, tb10, mc, prst, irq;
    logic [7:0]    fa, fb;
    logic [2:0]    rate;
    fbw_state_type st;
    int            failures = 0;
    int            n_tests = 0;
    int            n_prst = 0;
    int            m_st = 0, m_rate = 0, m_stat = 0, m_en = 0, p0, per;
    integer        seed = 2719;
    logic [7:0]    a, b;
    logic          tb;

    always #5 clk = ~clk;
    always @(negedge clk) if (prst === 1'b1) n_prst++;

    fbw_master_model fm_u (.sys_clk_in(clk), .good_out(good),
        .own_out(own), .from_m_out(fm), .param_out(sp), .mon_out(mon),
        .tb10_out(tb10), .fa_out(fa), .fb_out(fb), .take_out(mc));

    // ms shortened to 10 cycles, hunt trial to 2 ms
    fbw_watchdog #(.MS_CYCLES(10), .HUNT_MS(2)) dut_u (
        .sys_clk_in(clk), .rstn_in(rstn), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .frame_good_in(good),
        .frame_own_addr_in(own), .frame_from_master_in(fm),
        .set_param_in(sp), .param_mon_on_in(mon), .param_tb10_in(tb10),
        .param_factor_a_in(fa), .param_factor_b_in(fb),
        .master_change_in(mc), .rate_sel_out(rate), .guard_state_out(st),
        .proto_reset_out(prst), .irq_out(irq));

    task tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task settle();
        @(posedge clk);
        #1;
    endtask : settle

    task wr_reg(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        addr  <= ad;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task rd_reg(input logic [7:0] ad, input logic [31:0] m,
                input logic [31:0] e);
        @(posedge clk);
        addr <= ad;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        `CHK(rdata & m, e)
    endtask : rd_reg

    task model_cmp();
        `CHK(st, 2'(m_st))
        `CHK(rate, 3'(m_rate))
        `CHK(irq, |(2'(m_stat) & 2'(m_en)))
    endtask : model_cmp

    // waits for state or rate to move, bounded on both sides
    task wait_chg(input int lo, input int hi);
        int n;
        logic [4:0] v;
        n = 0;
        v = {st, rate};
        while ({st, rate} === v) begin
            @(posedge clk);
            #1;
            n++;
            if (n > hi) begin
                failures++;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, n, hi);
                tally_and_finish();
            end
        end
        `CHK(n > lo, 1'b1)
    endtask : wait_chg

    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        settle();
        model_cmp();
        rd_reg(`FBW_OFS_RATE_COUNT, 32'h0000FFFF, 32'h00000064);
        rd_reg(`FBW_OFS_FACTORS, 32'h0000FFFF, 32'h00000101);
        rd_reg(`FBW_OFS_CTRL, 32'hFFFFFFFF, 32'h00000000);
        rd_reg(8'h1C, 32'hFFFFFFFF, 32'h00000000);
        wr_reg(`FBW_OFS_STATUS, 32'hFFFFFFFF);
        rd_reg(`FBW_OFS_STATUS, 32'h00000003, 32'h00000000);
        $display("test reset done");

        fm_u.frame(1'b0, 1'b0);
        settle();
        m_st = 1;
        model_cmp();
        wr_reg(`FBW_OFS_RATE_COUNT, 32'h00000002);
        wr_reg(`FBW_OFS_IRQ_EN, 32'h00000001);
        m_en = 1;
        repeat (3) begin
            fm_u.frame(1'b1, 1'b0);
            settle();
            model_cmp();
            repeat (90) @(posedge clk);
        end
        fm_u.frame(1'b1, 1'b0);
        repeat (110) @(posedge clk);
        // frame without own address must not restart the guard
        fm_u.frame(1'b0, 1'b0);
        p0 = n_prst;
        wait_chg(30, 100);
        m_st = 0;
        m_stat = 2;
        model_cmp();
        settle();
        `CHK(n_prst, p0)
        $display("test rate guard done");

        repeat (3) begin
            wait_chg(6, 24);
            m_rate++;
            model_cmp();
        end
        fm_u.frame(1'b0, 1'b0);
        settle();
        m_st = 1;
        model_cmp();
        $display("test hunt done");

        fm_u.param(1'b1, 1'b0, 8'h02, 8'h03);
        settle();
        model_cmp();
        wr_reg(`FBW_OFS_CTRL, 32'h00000001);
        fm_u.param(1'b0, 1'b0, 8'h02, 8'h03);
        settle();
        model_cmp();
        fm_u.take_over();
        settle();
        model_cmp();
        for (int i = 0; i < 3; i++) begin
            wr_reg(`FBW_OFS_IRQ_EN, 32'(i & 1));
            m_en = i & 1;
            a = 8'(1 + ($unsigned($random(seed)) % 3));
            b = 8'(2 + ($unsigned($random(seed)) % 2));
            tb = 1'($random(seed));
            per = tb ? 100 : 10;
            fm_u.param(1'b1, tb, a, b);
            settle();
            m_st = 2;
            model_cmp();
            rd_reg(`FBW_OFS_FACTORS, 32'h0000FFFF, {16'h0000, b, a});
            rd_reg(`FBW_OFS_STATUS, 32'h0000037F,
                   32'h00000132 | (32'(tb) << 9));
            repeat (3) @(posedge clk);
            fm_u.frame(1'b0, 1'b1);
            settle();
            model_cmp();
            fm_u.take_over();
            p0 = n_prst;
            wait_chg((a * b - 1) * per - 2, a * b * per + 4);
            m_st = 1;
            m_stat = m_stat | 1;
            model_cmp();
            settle();
            `CHK(n_prst, p0 + 1)
            rd_reg(`FBW_OFS_IRQ_STAT, 32'h00000003, 32'(m_stat));
            wr_reg(`FBW_OFS_IRQ_CLR, 32'h00000003);
            m_stat = 0;
            settle();
            model_cmp();
            $display("test master guard %0d done", i);
        end
        tally_and_finish();
    end
endmodule : fieldbus_rate_and_master_watchdog_bench
